// *** hdl/pcd_map.svh ***
// Offsets, field positions, reset values and counts of the configuration region decoder.
// Included by the design; holds definitions only.
`ifndef PCD_MAP_SVH
`define PCD_MAP_SVH

`define PCD_OFF_VENDOR 8'h00
`define PCD_OFF_DEVICE 8'h02
`define PCD_OFF_COMMAND 8'h04

`define PCD_CMD_IO_BIT 0
`define PCD_CMD_MEM_BIT 1
`define PCD_CMD_MASTER_BIT 2
`define PCD_CMD_SPECIAL_BIT 3
`define PCD_CMD_MWI_BIT 4
`define PCD_CMD_SNOOP_BIT 5
`define PCD_CMD_RESET 1'b0

`define PCD_CFG_SIZE_MASK 32'h000000ff
`define PCD_CTRL_SIZE_MASK 32'h0003ffff
`define PCD_ROM_SIZE_MASK 32'h0000ffff
`define PCD_CTRL_SWAP_BIT 17

`define PCD_CTRL_PAGE_RB 5'h01
`define PCD_CTRL_PAGE_GPQ 5'h02
`define PCD_CTRL_PAGE_RAMDAC 5'h04
`define PCD_CTRL_PAGE_EEVMI 5'h05

`define PCD_VGA_MEM_LO 32'h000a0000
`define PCD_VGA_MEM_HI 32'h000bffff
`define PCD_VGA_IO_A_LO 32'h000003b0
`define PCD_VGA_IO_A_HI 32'h000003bb
`define PCD_VGA_IO_B_LO 32'h000003c0
`define PCD_VGA_IO_B_HI 32'h000003df
`define PCD_VGA_PAL_LO 32'h000003c6
`define PCD_VGA_PAL_HI 32'h000003c9

`define PCD_RB_DELAY 4
`define PCD_NUM_FUNC 2

`endif

// *** hdl/pcd_pkg.sv ***
// Types shared by the configuration region decoder and its address matcher.
// Assumes nothing of its surroundings.
package pcd_pkg;

    typedef enum logic [2:0] {
        PCD_CMD_CFG_RD = 3'h0,
        PCD_CMD_CFG_WR = 3'h1,
        PCD_CMD_MEM_RD = 3'h2,
        PCD_CMD_MEM_WR = 3'h3,
        PCD_CMD_IO_RD = 3'h4,
        PCD_CMD_IO_WR = 3'h5
    } pcd_cmd_t;

    typedef enum logic [2:0] {
        PCD_PORT_LOCAL = 3'h0,
        PCD_PORT_ROM = 3'h1,
        PCD_PORT_BYPASS = 3'h2,
        PCD_PORT_RAMDAC = 3'h3,
        PCD_PORT_EEVMI = 3'h4,
        PCD_PORT_GPQ = 3'h5
    } pcd_port_t;

    typedef enum logic [1:0] {
        PCD_AP_LOCAL = 2'h0,
        PCD_AP_ROM = 2'h1,
        PCD_AP_VGA = 2'h2
    } pcd_ap_mode_t;

    typedef enum logic [2:0] {
        PCD_ST_IDLE = 3'b001,
        PCD_ST_FWD_RD = 3'b010,
        PCD_ST_RB_WAIT = 3'b100
    } pcd_state_t;

    typedef struct packed {
        pcd_cmd_t cmd;
        logic [2:0] func;
        logic [31:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pcd_req_t;

    typedef struct packed {
        logic [31:0] base;
        logic [31:0] mask;
        logic enable;
        pcd_ap_mode_t mode;
    } pcd_ap_cfg_t;

    typedef struct packed {
        pcd_port_t port;
        logic write;
        logic [31:0] addr;
        logic [3:0] be;
        logic [31:0] data;
    } pcd_fwd_t;

    typedef struct packed {
        logic cfg;
        logic ctrl;
        logic ap1;
        logic ap2;
        logic rom;
        logic vga;
    } pcd_region_t;

    typedef struct packed {
        logic alternate_identity_select;
        logic legacy_display_decode_on;
        logic legacy_fixed_decode;
    } pcd_boot_t;

endpackage

// *** hdl/pcd_addr_match.sv ***
// Base and size compare for one relocatable region.
// Mask holds ones for the address bits that fall inside the region.
`timescale 1ns/1ps
module pcd_addr_match
    import pcd_pkg::*;
#(
    parameter int AW = 32
)
(
    input wire logic [AW-1:0] addr,
    input wire logic [AW-1:0] base,
    input wire logic [AW-1:0] mask,
    input wire logic enable,
    output logic hit
);
    assign hit = enable && ((addr & ~mask) == (base & ~mask));
endmodule

// *** hdl/pcd_top.sv ***
// Host bus slave front end: configuration header, region decode and forwarding.
// Assumes a host that presents one request at a time and owns the base registers.
//
// How it works
// RQ1: Reserved registers discard writes, read zero
// RQ2: Decode config, control, two apertures, ROM
// RQ3: Fixed legacy addresses only when configured
// RQ4: Configuration space reached by config commands
// RQ5: Per-function config space, shared other regions
// RQ6: Upper control half presented byte swapped
// RQ7: Two apertures, programmable size, disableable
// RQ8: Aperture may target ROM or legacy memory
// RQ9: Register read via tag, fixed delay
// RQ10: Legacy via bypass; separate RAMDAC, EEPROM ports
// RQ11: Soft reset clears control state, FSM runs
// RQ12: Host drops bus master before soft reset
// RQ13: Queue writes during soft reset discarded; code retries them instead unless retry_disable is set
// RQ14: Boot config loaded, addresses compared to bases
// RQ15: Vendor identity fixed, read-only
// RQ16: Device identity chosen by alternate select
// RQ17: I/O enable zero unless fixed legacy decode
// RQ18: Memory and master enables writable, reset zero
// RQ19: Command bits three, four read zero
// RQ20: Palette snoop bit gated by legacy decode
// RQ21: Cleared enable drops all but config
`timescale 1ns/1ps
`include "pcd_map.svh"
module pcd_top
    import pcd_pkg::*;
#(
    parameter int NUM_FUNC = `PCD_NUM_FUNC,
    parameter int RB_DELAY = `PCD_RB_DELAY,
    parameter logic [15:0] VENDOR_CODE = 16'h1c0d,     // Arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h0a10,     // Arbitrary value
    parameter logic [15:0] ALT_DEVICE_CODE = 16'h0a11  // Arbitrary value
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic soft_rst,
    input wire logic retry_disable,
    input wire logic boot_valid,
    input wire pcd_boot_t boot_word,
    input wire logic [31:0] ctrl_base,
    input wire pcd_ap_cfg_t ap1_cfg,
    input wire pcd_ap_cfg_t ap2_cfg,
    input wire logic [31:0] rom_base,
    input wire logic rom_enable,
    input wire logic req_valid,
    input wire pcd_req_t req,
    output logic req_ready,
    output logic ans_valid,
    output logic ans_claim,
    output logic ans_retry,
    output logic [31:0] ans_rdata,
    output logic fwd_valid,
    output pcd_fwd_t fwd,
    input wire logic [31:0] fwd_rdata,
    output logic rb_tag_valid,
    output logic [14:0] rb_tag,
    input wire logic [31:0] rb_data,
    output logic palette_snoop,
    output logic queue_flush,
    output logic bus_master_on,
    output pcd_region_t region_hit
);
    localparam int FW = (NUM_FUNC > 1) ? $clog2(NUM_FUNC) : 1;
    localparam logic [2:0] RB_LAST = 3'(RB_DELAY - 1);

    function automatic logic [31:0] swap32(input logic [31:0] d);
        swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction

    pcd_state_t state_reg;
    logic [2:0] cnt_reg;
    logic boot_loaded_reg;
    pcd_boot_t boot_reg;
    logic swap_reg;
    logic [NUM_FUNC-1:0] cmd_io_reg;
    logic [NUM_FUNC-1:0] cmd_mem_reg;
    logic [NUM_FUNC-1:0] cmd_master_reg;
    logic [NUM_FUNC-1:0] cmd_snoop_reg;
    logic ans_valid_reg, ans_claim_reg, ans_retry_reg;
    logic [31:0] ans_rdata_reg;
    logic fwd_valid_reg;
    pcd_fwd_t fwd_reg;
    logic rb_tag_valid_reg;
    logic [14:0] rb_tag_reg;
    logic snoop_reg, flush_reg;
    pcd_region_t region_reg;

    logic taken, vga_decode, mem_on, io_on, func_ok;
    logic [FW-1:0] fidx;
    logic hit_ctrl, hit_ap1, hit_ap2, hit_rom, hit_vga_mem, hit_vga_io, hit_pal;
    logic is_wr;
    logic [4:0] page;
    logic [15:0] cmd_view;
    logic dec_claim, dec_retry, dec_fwd, dec_rb, dec_snoop, dec_swap;
    pcd_port_t dec_port;
    logic [31:0] dec_rdata;
    pcd_region_t dec_region;

    assign req_ready = (state_reg == PCD_ST_IDLE) && boot_loaded_reg; // RQ14
    assign taken = req_valid && req_ready;
    assign vga_decode = boot_reg.legacy_display_decode_on && boot_reg.legacy_fixed_decode;
    assign mem_on = |cmd_mem_reg;
    assign io_on = |cmd_io_reg;
    assign func_ok = 32'(req.func) < NUM_FUNC;
    assign fidx = req.func[FW-1:0];
    assign is_wr = (req.cmd == PCD_CMD_MEM_WR) || (req.cmd == PCD_CMD_IO_WR);
    assign page = req.addr[16:12];

    pcd_addr_match u_ctrl (.addr(req.addr), .base(ctrl_base), .mask(`PCD_CTRL_SIZE_MASK),
        .enable(1'b1), .hit(hit_ctrl)); // RQ2 RQ14
    pcd_addr_match u_ap1 (.addr(req.addr), .base(ap1_cfg.base), .mask(ap1_cfg.mask),
        .enable(ap1_cfg.enable), .hit(hit_ap1)); // RQ7
    pcd_addr_match u_ap2 (.addr(req.addr), .base(ap2_cfg.base), .mask(ap2_cfg.mask),
        .enable(ap2_cfg.enable), .hit(hit_ap2)); // RQ7
    pcd_addr_match u_rom (.addr(req.addr), .base(rom_base), .mask(`PCD_ROM_SIZE_MASK),
        .enable(rom_enable), .hit(hit_rom)); // RQ2

    // Legacy ranges are scattered, so they are compared one by one
    assign hit_vga_mem = vga_decode && req.addr >= `PCD_VGA_MEM_LO
        && req.addr <= `PCD_VGA_MEM_HI; // RQ3
    assign hit_vga_io = vga_decode && ((req.addr >= `PCD_VGA_IO_A_LO
        && req.addr <= `PCD_VGA_IO_A_HI) || (req.addr >= `PCD_VGA_IO_B_LO
        && req.addr <= `PCD_VGA_IO_B_HI)); // RQ3
    assign hit_pal = req.addr >= `PCD_VGA_PAL_LO && req.addr <= `PCD_VGA_PAL_HI;

    // Command word as software sees it for the addressed function
    always_comb
    begin
        cmd_view = '0;
        if (func_ok)
        begin
            cmd_view[`PCD_CMD_IO_BIT] = cmd_io_reg[fidx] && vga_decode; // RQ17
            cmd_view[`PCD_CMD_MEM_BIT] = cmd_mem_reg[fidx]; // RQ18
            cmd_view[`PCD_CMD_MASTER_BIT] = cmd_master_reg[fidx]; // RQ18
            cmd_view[`PCD_CMD_SNOOP_BIT] = cmd_snoop_reg[fidx] && vga_decode; // RQ20
        end
    end

    always_comb
    begin
        dec_claim = 1'b0;
        dec_retry = 1'b0;
        dec_fwd = 1'b0;
        dec_rb = 1'b0;
        dec_snoop = 1'b0;
        dec_swap = 1'b0;
        dec_port = PCD_PORT_LOCAL;
        dec_rdata = '0;
        dec_region = '0;
        case (req.cmd)
            PCD_CMD_CFG_RD, PCD_CMD_CFG_WR:
            begin
                if (func_ok) // RQ4 RQ5 RQ21
                begin
                    dec_claim = 1'b1;
                    dec_region.cfg = 1'b1;
                    if (req.cmd == PCD_CMD_CFG_RD)
                    begin
                        if (req.addr[7:2] == `PCD_OFF_VENDOR >> 2)
                            dec_rdata = {boot_reg.alternate_identity_select ? ALT_DEVICE_CODE
                                : DEVICE_CODE, VENDOR_CODE}; // RQ15 RQ16
                        else if (req.addr[7:2] == `PCD_OFF_COMMAND >> 2)
                            dec_rdata = {16'h0000, cmd_view}; // RQ19
                        else
                            dec_rdata = '0; // RQ1
                    end
                end
            end
            PCD_CMD_MEM_RD, PCD_CMD_MEM_WR:
            begin
                if (mem_on) // RQ21
                begin
                    dec_claim = 1'b1;
                    if (hit_ctrl)
                    begin
                        dec_region.ctrl = 1'b1;
                        dec_swap = req.addr[`PCD_CTRL_SWAP_BIT]; // RQ6
                        case (page)
                            `PCD_CTRL_PAGE_RB:
                            begin
                                if (!is_wr && soft_rst)
                                    dec_retry = 1'b1;
                                else
                                    dec_rb = !is_wr; // RQ9
                            end
                            `PCD_CTRL_PAGE_GPQ:
                            begin
                                if (soft_rst && !(retry_disable && is_wr))
                                    dec_retry = 1'b1;
                                else if (!soft_rst)
                                    dec_fwd = 1'b1; // RQ13
                                dec_port = PCD_PORT_GPQ;
                            end
                            `PCD_CTRL_PAGE_RAMDAC:
                            begin
                                dec_fwd = 1'b1;
                                dec_port = PCD_PORT_RAMDAC; // RQ10
                            end
                            `PCD_CTRL_PAGE_EEVMI:
                            begin
                                dec_fwd = 1'b1;
                                dec_port = PCD_PORT_EEVMI; // RQ10
                            end
                            default: dec_rdata = '0; // RQ1
                        endcase
                    end
                    else if (hit_ap1 || hit_ap2)
                    begin
                        dec_region.ap1 = hit_ap1;
                        dec_region.ap2 = !hit_ap1;
                        dec_fwd = 1'b1;
                        case (hit_ap1 ? ap1_cfg.mode : ap2_cfg.mode) // RQ8
                            PCD_AP_ROM: dec_port = PCD_PORT_ROM;
                            PCD_AP_VGA: dec_port = PCD_PORT_BYPASS;
                            default: dec_port = PCD_PORT_LOCAL;
                        endcase
                    end
                    else if (hit_rom)
                    begin
                        dec_region.rom = 1'b1;
                        dec_fwd = 1'b1;
                        dec_port = PCD_PORT_ROM;
                    end
                    else if (hit_vga_mem)
                    begin
                        dec_region.vga = 1'b1;
                        dec_fwd = 1'b1;
                        dec_port = PCD_PORT_BYPASS; // RQ10
                    end
                    else
                        dec_claim = 1'b0;
                end
            end
            PCD_CMD_IO_RD, PCD_CMD_IO_WR:
            begin
                if (io_on && hit_vga_io) // RQ21 RQ3
                begin
                    if (hit_pal && is_wr && |cmd_snoop_reg)
                        dec_snoop = 1'b1; // RQ20
                    else
                    begin
                        dec_claim = 1'b1;
                        dec_region.vga = 1'b1;
                        dec_fwd = 1'b1;
                        dec_port = PCD_PORT_BYPASS; // RQ10
                    end
                end
            end
            default: dec_claim = 1'b0;
        endcase
        // Bypass traffic is retried while the queues are being cleared
        if (soft_rst && dec_fwd && dec_port == PCD_PORT_BYPASS)
        begin
            dec_fwd = 1'b0;
            dec_retry = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            boot_loaded_reg <= 1'b0;
            boot_reg <= '0;
        end
        else if (boot_valid && !boot_loaded_reg)
        begin
            boot_loaded_reg <= 1'b1; // RQ14
            boot_reg <= boot_word;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cmd_io_reg <= {NUM_FUNC{`PCD_CMD_RESET}};
            cmd_mem_reg <= {NUM_FUNC{`PCD_CMD_RESET}};
            cmd_master_reg <= {NUM_FUNC{`PCD_CMD_RESET}};
            cmd_snoop_reg <= {NUM_FUNC{`PCD_CMD_RESET}};
        end
        else if (taken && func_ok && req.cmd == PCD_CMD_CFG_WR
            && req.addr[7:2] == `PCD_OFF_COMMAND >> 2 && req.be[0])
        begin
            cmd_io_reg[fidx] <= req.wdata[`PCD_CMD_IO_BIT] && vga_decode; // RQ17
            cmd_mem_reg[fidx] <= req.wdata[`PCD_CMD_MEM_BIT]; // RQ18
            cmd_master_reg[fidx] <= req.wdata[`PCD_CMD_MASTER_BIT]; // RQ18
            cmd_snoop_reg[fidx] <= req.wdata[`PCD_CMD_SNOOP_BIT] && vga_decode; // RQ20
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= PCD_ST_IDLE;
            cnt_reg <= '0;
            swap_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                PCD_ST_IDLE:
                begin
                    if (taken)
                    begin
                        swap_reg <= dec_swap;
                        cnt_reg <= RB_LAST;
                        if (dec_rb)
                            state_reg <= PCD_ST_RB_WAIT;
                        else if (dec_fwd && !is_wr)
                            state_reg <= PCD_ST_FWD_RD;
                    end
                end
                PCD_ST_FWD_RD: state_reg <= PCD_ST_IDLE;
                PCD_ST_RB_WAIT:
                begin
                    if (cnt_reg == 3'h0)
                        state_reg <= PCD_ST_IDLE; // RQ9
                    else
                        cnt_reg <= cnt_reg - 3'h1;
                end
                default: state_reg <= PCD_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ans_valid_reg <= 1'b0;
            ans_claim_reg <= 1'b0;
            ans_retry_reg <= 1'b0;
            ans_rdata_reg <= '0;
        end
        else
        begin
            ans_valid_reg <= 1'b0;
            if (state_reg == PCD_ST_IDLE && taken && !dec_rb && !(dec_fwd && !is_wr))
            begin
                ans_valid_reg <= 1'b1;
                ans_claim_reg <= dec_claim;
                ans_retry_reg <= dec_retry;
                ans_rdata_reg <= dec_rdata;
            end
            else if (state_reg == PCD_ST_FWD_RD)
            begin
                ans_valid_reg <= 1'b1;
                ans_claim_reg <= 1'b1;
                ans_retry_reg <= 1'b0;
                ans_rdata_reg <= swap_reg ? swap32(fwd_rdata) : fwd_rdata; // RQ6
            end
            else if (state_reg == PCD_ST_RB_WAIT && cnt_reg == 3'h0)
            begin
                ans_valid_reg <= 1'b1;
                ans_claim_reg <= 1'b1;
                ans_retry_reg <= 1'b0;
                ans_rdata_reg <= swap_reg ? swap32(rb_data) : rb_data; // RQ9 RQ6
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fwd_valid_reg <= 1'b0;
            fwd_reg <= '0;
        end
        else
        begin
            fwd_valid_reg <= taken && dec_fwd; // RQ1 RQ13
            if (taken && dec_fwd)
            begin
                fwd_reg.port <= dec_port;
                fwd_reg.write <= is_wr;
                fwd_reg.addr <= req.addr;
                fwd_reg.be <= dec_swap ? {req.be[0], req.be[1], req.be[2], req.be[3]} : req.be;
                fwd_reg.data <= dec_swap ? swap32(req.wdata) : req.wdata; // RQ6
            end
        end
    end

    // Tag state belongs to the control region and is cleared by soft reset
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rb_tag_valid_reg <= 1'b0;
            rb_tag_reg <= '0;
        end
        else if (soft_rst)
        begin
            rb_tag_valid_reg <= 1'b0;
            rb_tag_reg <= '0; // RQ11
        end
        else
        begin
            rb_tag_valid_reg <= taken && dec_rb;
            if (taken && dec_rb)
                rb_tag_reg <= req.addr[16:2]; // RQ9
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            snoop_reg <= 1'b0;
            flush_reg <= 1'b0;
            region_reg <= '0;
        end
        else
        begin
            snoop_reg <= taken && dec_snoop;
            flush_reg <= soft_rst; // RQ11
            if (taken)
                region_reg <= dec_region;
        end
    end

    assign ans_valid = ans_valid_reg;
    assign ans_claim = ans_claim_reg;
    assign ans_retry = ans_retry_reg;
    assign ans_rdata = ans_rdata_reg;
    assign fwd_valid = fwd_valid_reg;
    assign fwd = fwd_reg;
    assign rb_tag_valid = rb_tag_valid_reg;
    assign rb_tag = rb_tag_reg;
    assign palette_snoop = snoop_reg;
    assign queue_flush = flush_reg;
    assign bus_master_on = |cmd_master_reg; // RQ12
    assign region_hit = region_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_rb_wait;
        !ans_valid [*3];
    endsequence

    a_reserved_reads_zero: assert property (taken && req.cmd == PCD_CMD_CFG_RD && func_ok // RQ1
        && req.addr[7:2] > 6'h01 |=> ans_valid && ans_claim && ans_rdata == 32'h0)
        else $error("reserved config read not zero");
    a_ident_value: assert property (taken && req.cmd == PCD_CMD_CFG_RD && func_ok // RQ16
        && req.addr[7:2] == 6'h00 |=> ans_rdata[15:0] == VENDOR_CODE
        && ans_rdata[31:16] == (boot_reg.alternate_identity_select ? ALT_DEVICE_CODE
        : DEVICE_CODE))
        else $error("identity word wrong");
    a_cmd_ro_bits: assert property (taken && req.cmd == PCD_CMD_CFG_RD && func_ok // RQ19
        && req.addr[7:2] == 6'h01 |=> ans_rdata[4:3] == 2'b00
        && (vga_decode || (!ans_rdata[0] && !ans_rdata[5])))
        else $error("command read-only bits set");
    a_mem_off_quiet: assert property (taken && !mem_on // RQ21
        && (req.cmd == PCD_CMD_MEM_RD || req.cmd == PCD_CMD_MEM_WR)
        |=> ans_valid && !ans_claim && !fwd_valid)
        else $error("memory claimed while disabled");
    a_rb_latency: assert property (rb_tag_valid |=> s_rb_wait ##1 ans_valid) // RQ9
        else $error("readback answer off time");
    a_swap_upper: assert property (taken && dec_fwd && dec_region.ctrl // RQ6
        && req.addr[`PCD_CTRL_SWAP_BIT] |=> fwd_valid && fwd.data == swap32($past(req.wdata)))
        else $error("upper control half not swapped");
    a_gpq_discard: assert property (taken && soft_rst && retry_disable && mem_on // RQ13
        && req.cmd == PCD_CMD_MEM_WR && hit_ctrl && page == `PCD_CTRL_PAGE_GPQ
        |=> ans_claim && !ans_retry && !fwd_valid)
        else $error("queue write during soft reset not discarded");
    a_ap_legacy_route: assert property (taken && dec_region.ap1 && !soft_rst // RQ8
        && ap1_cfg.mode == PCD_AP_VGA |=> fwd_valid && fwd.port == PCD_PORT_BYPASS)
        else $error("aperture legacy route wrong");
    a_boot_first: assert property (!boot_loaded_reg |-> !req_ready) // RQ14
        else $error("request accepted before boot load");
    a_io_gated: assert property (!vga_decode |-> cmd_io_reg == '0) // RQ17
        else $error("io enable set without legacy decode");
endmodule

// *** sim/pcd_host_model.sv ***
// Host bridge model: one request at a time, answers forwarded and read-back ports.
// Assumes the front end's request handshake and a four-clock read-back delay.
`timescale 1ns/1ps
module pcd_host_model
    import pcd_pkg::*;
(
    input wire logic core_clk,
    input wire logic req_ready,
    input wire logic ans_valid,
    input wire logic fwd_valid,
    input wire logic rb_tag_valid,
    input wire logic [14:0] rb_tag,
    output logic req_valid = 1'b0,
    output pcd_req_t req = '0,
    output logic [31:0] fwd_rdata,
    output logic [31:0] rb_data
);
    logic [14:0] tag_reg = 15'h0;
    logic [2:0] age_reg = 3'h0;
    int timeouts = 0;
    // Data is good only in the sampled cycle, garbage around it
    assign fwd_rdata = fwd_valid ? 32'h5eed_c0de : 32'ha112_3f21;
    assign rb_data = (age_reg == 3'h3) ? {17'h0, tag_reg} : 32'hffff_ffff;
    always_ff @(posedge core_clk)
    begin
        if (rb_tag_valid)
        begin
            tag_reg <= rb_tag;
            age_reg <= 3'h1;
        end
        else if (age_reg != 3'h0)
            age_reg <= age_reg + 3'h1;
    end
    task automatic access(input pcd_cmd_t c, input logic [2:0] f,
        input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(negedge core_clk);
        req_valid = 1'b1;
        req = '{c, f, a, 4'hf, d};
        while (req_ready !== 1'b1 && n < 50)
        begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        req_valid = 1'b0;
        while (ans_valid !== 1'b1 && n < 50)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 50)
            timeouts++;
    endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the configuration region decoder.
// Assumes the host model issues requests and feeds the forwarding ports.
`timescale 1ns/1ps
module tb_top;
    import pcd_pkg::*;
    localparam logic [31:0] CB = 32'h0100_0000;
    localparam logic [31:0] AP = 32'h0200_0000;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic soft_rst = 1'b0;
    logic retry_disable = 1'b1;
    logic boot_valid = 1'b1;
    pcd_boot_t boot_word = 3'b110;
    logic [31:0] ctrl_base = CB;
    logic [31:0] rom_base = 32'h0400_0000;
    logic rom_enable = 1'b0;
    pcd_ap_cfg_t ap1_cfg = '{AP, 32'h000f_ffff, 1'b1, PCD_AP_LOCAL};
    pcd_ap_cfg_t ap2_cfg = '{32'h0300_0000, 32'h000f_ffff, 1'b0, PCD_AP_LOCAL};
    logic req_valid, req_ready, ans_valid, ans_claim, ans_retry, fwd_valid;
    logic rb_tag_valid, bus_master_on, palette_snoop, queue_flush;
    pcd_fwd_t fwd;
    pcd_region_t region_hit;
    logic [31:0] ans_rdata, fwd_rdata, rb_data;
    logic [14:0] rb_tag;
    pcd_req_t req;
    int miscompares = 0;
    int comparisons = 0;
    always #10 core_clk = ~core_clk;
    pcd_top u_dut (.*);
    pcd_host_model u_host (.*);
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        miscompares += u_host.timeouts;
        if (miscompares == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic t_ident();
        u_host.access(PCD_CMD_CFG_WR, 3'h0, 32'h0, 32'hffff_ffff);
        u_host.access(PCD_CMD_CFG_RD, 3'h0, 32'h0, 32'h0);
        chk(ans_rdata, 32'h0a11_1c0d);
        u_host.access(PCD_CMD_CFG_RD, 3'h0, 32'h4, 32'h0);
        chk(ans_rdata[15:0], 16'h0);
    endtask
    task automatic t_command();
        u_host.access(PCD_CMD_CFG_WR, 3'h0, 32'h4, 32'hffff);
        u_host.access(PCD_CMD_CFG_RD, 3'h0, 32'h4, 32'h0);
        chk(ans_rdata[15:0], 16'h0006);
        chk(bus_master_on, 1'b1);
        u_host.access(PCD_CMD_CFG_RD, 3'h1, 32'h4, 32'h0);
        chk(ans_rdata[15:0], 16'h0);
    endtask
    task automatic t_memory();
        u_host.access(PCD_CMD_MEM_WR, 3'h0, CB + 32'h2_4000, 32'h1122_3344);
        chk({fwd.port, fwd.data}, {PCD_PORT_RAMDAC, 32'h4433_2211});
        chk(region_hit, 6'h10);
        u_host.access(PCD_CMD_MEM_RD, 3'h1, AP + 32'h40, 32'h0);
        chk({ans_retry, ans_claim, ans_rdata}, {2'b01, 32'h5eed_c0de});
        u_host.access(PCD_CMD_MEM_RD, 3'h0, CB + 32'h3010, 32'h0);
        chk({ans_retry, ans_claim, ans_rdata}, {2'b01, 32'h0});
        u_host.access(PCD_CMD_MEM_RD, 3'h0, CB + 32'h1010, 32'h0);
        chk({ans_retry, ans_claim, ans_rdata}, {2'b01, 32'h404});
        ap1_cfg.enable = 1'b0;
        u_host.access(PCD_CMD_MEM_RD, 3'h0, AP + 32'h40, 32'h0);
        chk(ans_claim, 1'b0);
        ap1_cfg.enable = 1'b1;
        u_host.access(PCD_CMD_CFG_WR, 3'h0, 32'h4, 32'h0004);
        u_host.access(PCD_CMD_MEM_RD, 3'h0, AP + 32'h40, 32'h0);
        chk(ans_claim, 1'b0);
    endtask
    task automatic t_soft();
        u_host.access(PCD_CMD_CFG_WR, 3'h0, 32'h4, 32'h0002);
        chk(bus_master_on, 1'b0);
        soft_rst = 1'b1;
        u_host.access(PCD_CMD_MEM_WR, 3'h0, CB + 32'h2000, 32'h1234);
        chk({queue_flush, ans_retry, ans_claim}, 3'b101);
        u_host.access(PCD_CMD_MEM_RD, 3'h0, CB + 32'h1010, 32'h0);
        chk({ans_retry, ans_claim}, 2'b11);
        soft_rst = 1'b0;
    endtask
    task automatic t_legacy();
        @(negedge core_clk);
        nrst = 1'b0;
        boot_word = 3'b011;
        ap1_cfg.mode = PCD_AP_VGA;
        ap2_cfg = '{32'h0300_0000, 32'h000f_ffff, 1'b1, PCD_AP_ROM};
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        u_host.access(PCD_CMD_CFG_RD, 3'h0, 32'h0, 32'h0);
        chk(ans_rdata, 32'h0a10_1c0d);
        u_host.access(PCD_CMD_CFG_WR, 3'h0, 32'h4, 32'h0023);
        u_host.access(PCD_CMD_CFG_RD, 3'h0, 32'h4, 32'h0);
        chk(ans_rdata[15:0], 16'h0023);
        u_host.access(PCD_CMD_IO_WR, 3'h0, 32'h3c8, 32'h0);
        chk({palette_snoop, ans_claim}, 2'b10);
        u_host.access(PCD_CMD_IO_RD, 3'h0, 32'h3b4, 32'h0);
        chk({ans_claim, fwd.port, region_hit}, {1'b1, PCD_PORT_BYPASS, 6'h01});
        u_host.access(PCD_CMD_MEM_WR, 3'h0, AP + 32'h10, 32'h0);
        chk({fwd.write, fwd.port}, {1'b1, PCD_PORT_BYPASS});
        u_host.access(PCD_CMD_MEM_WR, 3'h0, 32'h0300_0010, 32'h0);
        chk({fwd.port, region_hit}, {PCD_PORT_ROM, 6'h04});
        u_host.access(PCD_CMD_MEM_WR, 3'h0, 32'h000a_0000, 32'h0);
        chk({fwd.port, region_hit}, {PCD_PORT_BYPASS, 6'h01});
    endtask
    initial
    begin
        repeat (12) @(negedge core_clk);
        nrst = 1'b1;
        t_ident();
        t_command();
        t_memory();
        t_soft();
        t_legacy();
        print_verdict();
    end
    initial
    begin
        #100000;
        miscompares++;
        print_verdict();
    end
endmodule
